// File: hdl/cefm_alert_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "cefm_params.svh"

module cefm_alert_pulse #(
    parameter int LEN = `CEFM_ALERT_CYC
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable
    input wire logic fire, // at least one unmasked event this cycle
    output logic alert_n // active-low alert pulse, from a flop
);

    cefm_pkg::cefm_alert_st_t st_r;
    cefm_pkg::cefm_alert_st_t st_nxt;

    // an event during a pulse or its gap is kept pending and yields one more pulse; further events in that time merge into it
    always_comb begin
        st_nxt = st_r;
        if (fire && st_r.state != cefm_pkg::CEFM_ALERT_IDLE) begin
            st_nxt.pending = 1'b1;
        end
        unique case (st_r.state)
            cefm_pkg::CEFM_ALERT_IDLE: begin
                if (fire || st_r.pending) begin
                    st_nxt.state = cefm_pkg::CEFM_ALERT_LOW;
                    st_nxt.cnt = 16'(LEN - 1);
                    st_nxt.alert_n = 1'b0;
                    st_nxt.pending = 1'b0;
                end
            end
            cefm_pkg::CEFM_ALERT_LOW: begin
                if (st_r.cnt == 16'h0000) begin
                    st_nxt.state = cefm_pkg::CEFM_ALERT_GAP;
                    st_nxt.alert_n = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end
            end
            cefm_pkg::CEFM_ALERT_GAP: begin
                st_nxt.state = cefm_pkg::CEFM_ALERT_IDLE;
            end
            default: begin
                st_nxt.state = cefm_pkg::CEFM_ALERT_IDLE;
                st_nxt.alert_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{state: cefm_pkg::CEFM_ALERT_IDLE, cnt: 16'h0000, pending: 1'b0, alert_n: 1'b1};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign alert_n = st_r.alert_n;

endmodule : cefm_alert_pulse

`default_nettype wire

// File: hdl/cefm_edge_watch.sv
`timescale 1ns/1ps
`default_nettype none

module cefm_edge_watch #(
    parameter int W = 23
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable, freezes state while low
    input wire logic [W-1:0] level, // watched levels
    output logic [W-1:0] rise, // rising edge seen this cycle
    output logic [W-1:0] change // any change seen this cycle
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic armed;
    } cefm_edge_st_t;

    cefm_edge_st_t st_r;
    cefm_edge_st_t st_nxt;

    // first enabled cycle only loads history, so reset values never look like events
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = level;
        st_nxt.armed = 1'b1;
        rise = st_r.armed ? (level & ~st_r.prev) : '0;
        change = st_r.armed ? (level ^ st_r.prev) : '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

endmodule : cefm_edge_watch

`default_nettype wire

// File: hdl/cefm_params.svh
`ifndef CEFM_PARAMS_SVH
`define CEFM_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CEFM_OFS_CHG_FLAG_A 8'h0F
`define CEFM_OFS_CHG_FLAG_B 8'h10
`define CEFM_OFS_FAULT_FLAG 8'h11
`define CEFM_OFS_MASK_A 8'h12
`define CEFM_OFS_MASK_B 8'h13
`define CEFM_OFS_FAULT_MASK 8'h14

// ----------------------------------------------------------------------------
// reset values and implemented bits (reserved bits read zero)
// ----------------------------------------------------------------------------
`define CEFM_RST_VAL 8'h00
`define CEFM_IMPL_FAULT 8'hF9
`define CEFM_IMPL_CHG_A 8'hF9
`define CEFM_IMPL_CHG_B 8'h97

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CEFM_BIT_OVP 7
`define CEFM_BIT_SHUT 6
`define CEFM_BIT_BATTERY_OVERVOLTAGE 5
`define CEFM_BIT_TMR 4
`define CEFM_BIT_SHORT 3
`define CEFM_BIT_BUCK 0
`define CEFM_BIT_DONE 7
`define CEFM_BIT_ICUR 6
`define CEFM_BIT_IVOLT 5
`define CEFM_BIT_HEAT 4
`define CEFM_BIT_HOST 3
`define CEFM_BIT_CHARGE 0
`define CEFM_BIT_SUPPLY 7
`define CEFM_BIT_SOURCE 4
`define CEFM_BIT_THERM 2
`define CEFM_BIT_OPTIM 1
`define CEFM_BIT_MINSYS 0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CEFM_CLK_PERIOD_NS 10
`define CEFM_ALERT_PULSE_NS 1000
`define CEFM_ALERT_CYC ((`CEFM_ALERT_PULSE_NS + `CEFM_CLK_PERIOD_NS - 1) / `CEFM_CLK_PERIOD_NS)

`endif

// File: hdl/cefm_pkg.sv
`default_nettype none

package cefm_pkg;

    // ------------------------------------------------------------------------
    // alert pulse sequencer
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CEFM_ALERT_IDLE = 2'b00,
        CEFM_ALERT_LOW = 2'b01,
        CEFM_ALERT_GAP = 2'b10
    } cefm_alert_state_t;

    typedef struct packed {
        cefm_alert_state_t state;
        logic [15:0] cnt;
        logic pending;
        logic alert_n;
    } cefm_alert_st_t;

    // ------------------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] fault_flag;
        logic [7:0] chg_flag_a;
        logic [7:0] chg_flag_b;
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] fault_mask;
        logic [7:0] rdata;
    } cefm_regs_t;

endpackage : cefm_pkg

`default_nettype wire

// File: hdl/cefm_top.sv
// Behaviour
// - input overvoltage entry sets fault flag bit 7; reads 0 otherwise
// - die overheat shutdown entry sets fault flag bit 6
// - battery overvoltage entry sets fault flag bit 5
// - safety timer expiry rising edge sets fault flag bit 4
// - converter stop from boost overload (system short) sets fault flag bit 3
// - any buck output fault sets fault flag bit 0
// - fault flag register at 11h, resets to 00h, read-only
// - reserved bits of flag and mask registers always read zero
// - register-reset command clears flags and masks; watchdog expiry leaves them
// - mask 12h bit 7 gates conversion-complete alert, one-shot mode only
// - mask 12h bit 6 gates input current regulation entry alert
// - mask 12h bit 5 gates input voltage regulation entry alert
// - mask 12h bit 4 gates die thermal regulation entry alert
// - mask 12h bit 3 gates host timeout rising edge alert
// - mask 12h bit 0 gates charge state field change alert
// - mask 13h bit 7 gates supply good toggle alert
// - mask 13h bit 4 gates source type field change alert
// - mask 13h bit 2 gates thermistor zone field change alert
// - mask 13h bit 1 gates current optimizer rising edge alert
// - mask 13h bit 0 gates minimum system regulation entry or exit alert
// - fault mask at 14h, charger masks at 12h and 13h, all reset 00h
// - fault mask bits mirror fault flag positions; 1 blocks the alert
// - charger flags latch on regulation edges, state changes, supply good toggles
`timescale 1ns/1ps
`default_nettype none
`include "cefm_params.svh"

module cefm_top #(
    parameter int ALERT_LEN = `CEFM_ALERT_CYC
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable, freezes all state while low
    input wire logic [7:0] reg_addr, // register address from the serial bus engine
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic reg_reset_cmd, // register-reset command pulse
    input wire logic one_shot_mode, // converter in one-shot conversion mode
    input wire logic conversion_done, // conversion complete level
    input wire logic input_overvoltage, // input overvoltage fault level
    input wire logic die_overheat_shutdown, // die shutdown fault level
    input wire logic battery_overvoltage, // battery overvoltage fault level
    input wire logic safety_timer_expired, // charge safety timer expired level
    input wire logic system_short, // switching stopped on boost overload
    input wire logic buck_output_fault, // any buck output fault level
    input wire logic input_current_regulation, // in input current regulation
    input wire logic input_voltage_regulation, // in input voltage regulation
    input wire logic die_heat_regulation, // in die thermal regulation
    input wire logic host_timeout_state, // host watchdog expired status
    input wire logic [2:0] charge_state_field, // charge state code
    input wire logic supply_good, // input power good
    input wire logic [2:0] source_type_field, // input source type code
    input wire logic [2:0] thermistor_zone_field, // thermistor zone code
    input wire logic current_optimizer_state, // current optimizer status
    input wire logic minimum_system_voltage, // in minimum system voltage regulation
    output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
    output logic alert_n // active-low alert pulse
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] ofs);
        f_hit = (addr == ofs);
    endfunction : f_hit

    // an unmasked event is an event whose mask bit is zero
    function automatic logic f_unmasked(input logic [7:0] evt, input logic [7:0] mask);
        f_unmasked = |(evt & ~mask);
    endfunction : f_unmasked

    // flags: set wins over clear; clear is a read of this register or reset cmd
    function automatic logic [7:0] f_flag(input logic [7:0] cur, input logic [7:0] evt,
                                          input logic clr);
        f_flag = (clr ? 8'h00 : cur) | evt;
    endfunction : f_flag

    // ------------------------------------------------------------------------
    // edge and change detection
    // ------------------------------------------------------------------------
    localparam int NW = 23;

    logic [NW-1:0] lvl;
    logic [NW-1:0] rise;
    logic [NW-1:0] chg;

    assign lvl = {thermistor_zone_field, source_type_field, charge_state_field,
                  minimum_system_voltage, current_optimizer_state, supply_good,
                  host_timeout_state, die_heat_regulation, input_voltage_regulation,
                  input_current_regulation, conversion_done, buck_output_fault,
                  system_short, safety_timer_expired, battery_overvoltage,
                  die_overheat_shutdown, input_overvoltage};

    cefm_edge_watch #(
        .W(NW)
    ) u_edge (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .level(lvl),
        .rise(rise),
        .change(chg)
    );

    // ------------------------------------------------------------------------
    // event vectors, laid out at their flag positions
    // ------------------------------------------------------------------------
    logic [7:0] fault_evt;
    logic [7:0] chg_a_evt;
    logic [7:0] chg_b_evt;

    always_comb begin
        fault_evt = 8'h00;
        fault_evt[`CEFM_BIT_OVP] = rise[0];
        fault_evt[`CEFM_BIT_SHUT] = rise[1];
        fault_evt[`CEFM_BIT_BATTERY_OVERVOLTAGE] = rise[2];
        fault_evt[`CEFM_BIT_TMR] = rise[3];
        fault_evt[`CEFM_BIT_SHORT] = rise[4];
        fault_evt[`CEFM_BIT_BUCK] = rise[5];

        chg_a_evt = 8'h00;
        // completion counts only in one-shot mode; continuous mode never flags it
        chg_a_evt[`CEFM_BIT_DONE] = rise[6] & one_shot_mode;
        chg_a_evt[`CEFM_BIT_ICUR] = rise[7];
        chg_a_evt[`CEFM_BIT_IVOLT] = rise[8];
        chg_a_evt[`CEFM_BIT_HEAT] = rise[9];
        chg_a_evt[`CEFM_BIT_HOST] = rise[10];
        chg_a_evt[`CEFM_BIT_CHARGE] = |chg[16:14];

        chg_b_evt = 8'h00;
        chg_b_evt[`CEFM_BIT_SUPPLY] = chg[11];
        chg_b_evt[`CEFM_BIT_SOURCE] = |chg[19:17];
        chg_b_evt[`CEFM_BIT_THERM] = |chg[22:20];
        chg_b_evt[`CEFM_BIT_OPTIM] = rise[12];
        chg_b_evt[`CEFM_BIT_MINSYS] = chg[13];
    end

    // ------------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------------
    cefm_pkg::cefm_regs_t st_r;
    cefm_pkg::cefm_regs_t st_nxt;

    logic rd_fault;
    logic rd_chg_a;
    logic rd_chg_b;
    logic [7:0] rd_val;
    logic fire;

    assign rd_fault = reg_rd & f_hit(reg_addr, `CEFM_OFS_FAULT_FLAG);
    assign rd_chg_a = reg_rd & f_hit(reg_addr, `CEFM_OFS_CHG_FLAG_A);
    assign rd_chg_b = reg_rd & f_hit(reg_addr, `CEFM_OFS_CHG_FLAG_B);

    // read mux; unmapped addresses answer zero
    always_comb begin
        rd_val = 8'h00;
        if (f_hit(reg_addr, `CEFM_OFS_FAULT_FLAG)) begin
            rd_val = st_r.fault_flag & `CEFM_IMPL_FAULT;
        end else if (f_hit(reg_addr, `CEFM_OFS_CHG_FLAG_A)) begin
            rd_val = st_r.chg_flag_a & `CEFM_IMPL_CHG_A;
            rd_val[`CEFM_BIT_DONE] = st_r.chg_flag_a[`CEFM_BIT_DONE] & one_shot_mode;
        end else if (f_hit(reg_addr, `CEFM_OFS_CHG_FLAG_B)) begin
            rd_val = st_r.chg_flag_b & `CEFM_IMPL_CHG_B;
        end else if (f_hit(reg_addr, `CEFM_OFS_MASK_A)) begin
            rd_val = st_r.mask_a;
        end else if (f_hit(reg_addr, `CEFM_OFS_MASK_B)) begin
            rd_val = st_r.mask_b;
        end else if (f_hit(reg_addr, `CEFM_OFS_FAULT_MASK)) begin
            rd_val = st_r.fault_mask;
        end
    end

    always_comb begin
        st_nxt = st_r;

        // flags latch whatever the masks say; the read clears, but an event
        // arriving in the same cycle as the read is kept for the next read
        st_nxt.fault_flag = f_flag(st_r.fault_flag, fault_evt,
                                   rd_fault | reg_reset_cmd);
        st_nxt.chg_flag_a = f_flag(st_r.chg_flag_a, chg_a_evt,
                                   rd_chg_a | reg_reset_cmd);
        st_nxt.chg_flag_b = f_flag(st_r.chg_flag_b, chg_b_evt,
                                   rd_chg_b | reg_reset_cmd);

        // mask writes keep reserved bits at zero; flag registers ignore writes
        if (reg_wr && f_hit(reg_addr, `CEFM_OFS_MASK_A)) begin
            st_nxt.mask_a = reg_wdata & `CEFM_IMPL_CHG_A;
        end
        if (reg_wr && f_hit(reg_addr, `CEFM_OFS_MASK_B)) begin
            st_nxt.mask_b = reg_wdata & `CEFM_IMPL_CHG_B;
        end
        if (reg_wr && f_hit(reg_addr, `CEFM_OFS_FAULT_MASK)) begin
            st_nxt.fault_mask = reg_wdata & `CEFM_IMPL_FAULT;
        end
        // register reset beats a simultaneous write; watchdog expiry has no path here
        if (reg_reset_cmd) begin
            st_nxt.mask_a = `CEFM_RST_VAL;
            st_nxt.mask_b = `CEFM_RST_VAL;
            st_nxt.fault_mask = `CEFM_RST_VAL;
        end

        if (reg_rd) begin
            st_nxt.rdata = rd_val;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;

    // ------------------------------------------------------------------------
    // alert generation
    // ------------------------------------------------------------------------
    // each mask bit sits at the position of the event it gates; simultaneous
    // events collapse into one pulse, which the host resolves by reading flags
    assign fire = f_unmasked(fault_evt, st_r.fault_mask)
                | f_unmasked(chg_a_evt, st_r.mask_a)
                | f_unmasked(chg_b_evt, st_r.mask_b);

    cefm_alert_pulse #(
        .LEN(ALERT_LEN)
    ) u_alert (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .fire(fire & ce),
        .alert_n(alert_n)
    );

endmodule : cefm_top

`default_nettype wire

// File: sim/cefm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cefm_host_model (
    input wire logic clk, // system clock
    input wire logic [7:0] reg_rdata, // read data from the block
    output logic [7:0] reg_addr, // register address
    output logic reg_wr, // write strobe
    output logic [7:0] reg_wdata, // write data
    output logic reg_rd // read strobe
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // strobes last one cycle; released write data is inverted so it never lingers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : cefm_host_model

`default_nettype wire

// File: sim/cefm_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cefm_top_chk #(
    parameter int ALERT_LEN = 4
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe
    input wire logic reg_reset_cmd, // register-reset command
    input wire logic input_overvoltage, // input overvoltage level
    input wire logic [7:0] reg_rdata, // read data
    input wire logic alert_n // active-low alert pulse
);
    // ------------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------------
    logic [15:0] low_cnt_r;
    logic [7:0] fmask_r;
    logic [7:0] rd_addr_r;
    logic armed_r;
    logic rd_seen_r;

    // shadow of the fault mask, so the alert check knows whether a pulse is due
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_r <= 16'h0000;
            fmask_r <= 8'h00;
            rd_addr_r <= 8'h00;
            armed_r <= 1'b0;
            rd_seen_r <= 1'b0;
        end else begin
            rd_seen_r <= ce && reg_rd;
            rd_addr_r <= reg_addr;
            if (ce) begin
                low_cnt_r <= alert_n ? 16'h0000 : low_cnt_r + 16'h0001;
                armed_r <= 1'b1;
                if (reg_reset_cmd) begin
                    fmask_r <= 8'h00;
                end else if (reg_wr && reg_addr == 8'h14) begin
                    fmask_r <= reg_wdata & 8'hF9;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ovp_entry;
        ce && $past(ce) && armed_r && $rose(input_overvoltage) && !reg_reset_cmd;
    endsequence

    sequence s_pulse_start;
        ##[1:4] !alert_n;
    endsequence

    a_alert_length: assert property ($rose(alert_n) |-> low_cnt_r == ALERT_LEN)
        else $error("alert pulse length wrong");
    a_alert_gap: assert property ($rose(alert_n) |=> alert_n)
        else $error("alert pulses run together");
    a_ovp_alert: assert property (s_ovp_entry ##0 (!fmask_r[7] && alert_n && $past(alert_n)) |-> s_pulse_start)
        else $error("unmasked overvoltage gave no alert");
    a_fault_rsvd: assert property (rd_seen_r && rd_addr_r == 8'h11 |-> reg_rdata[2:1] == 2'b00)
        else $error("fault flag reserved bits not zero");
    a_mask_a_rsvd: assert property (rd_seen_r && (rd_addr_r == 8'h12 || rd_addr_r == 8'h14) |-> reg_rdata[2:1] == 2'b00)
        else $error("mask reserved bits not zero");
    a_mask_b_rsvd: assert property (rd_seen_r && rd_addr_r == 8'h13 |-> (reg_rdata & 8'h68) == 8'h00)
        else $error("second mask reserved bits not zero");
    a_unmapped_zero: assert property (rd_seen_r && (rd_addr_r < 8'h0F || rd_addr_r > 8'h14) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!rd_seen_r |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_fmask_readback: assert property (rd_seen_r && rd_addr_r == 8'h14 |-> reg_rdata == $past(fmask_r))
        else $error("fault mask readback wrong");
endmodule : cefm_top_chk

`default_nettype wire

// File: sim/cefm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cefm_top_tb;
    localparam int ALERT_LEN = 4;
    localparam int EV_REG [17] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
    localparam int EV_BIT [17] = '{7, 6, 5, 4, 3, 0, 7, 4, 2, 1, 0, 7, 6, 5, 4, 3, 0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_reset_cmd = 1'b0;
    logic one_shot_mode = 1'b0;
    logic [16:0] ev = 17'h0_0000;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, bm;
    logic reg_wr, reg_rd, alert_n;
    int fail_count = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    cefm_host_model u_cefm_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    cefm_top #(.ALERT_LEN(ALERT_LEN)) u_cefm_top (.clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_reset_cmd(reg_reset_cmd),
        .one_shot_mode(one_shot_mode), .conversion_done(ev[0]), .input_current_regulation(ev[1]),
        .input_voltage_regulation(ev[2]), .die_heat_regulation(ev[3]), .host_timeout_state(ev[4]),
        .charge_state_field({3{ev[5]}}), .supply_good(ev[6]), .source_type_field({3{ev[7]}}),
        .thermistor_zone_field({3{ev[8]}}), .current_optimizer_state(ev[9]), .minimum_system_voltage(ev[10]),
        .input_overvoltage(ev[11]), .die_overheat_shutdown(ev[12]), .battery_overvoltage(ev[13]),
        .safety_timer_expired(ev[14]), .system_short(ev[15]), .buck_output_fault(ev[16]),
        .reg_rdata(reg_rdata), .alert_n(alert_n));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        u_cefm_host_model.rd(a, rv);
        check(rv, exp);
    endtask : rd_check

    // counts low cycles of the next alert pulse; zero when none starts
    task automatic pulse(input logic want);
        int n;
        int w;
        n = 0;
        w = 0;
        while (alert_n === 1'b1 && w < 6) begin
            @(negedge clk);
            w++;
        end
        while (alert_n === 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(8'(n), want ? 8'(ALERT_LEN) : 8'h00);
    endtask : pulse

    // only: mask just source i; otherwise open just source i
    task automatic set_masks(input int i, input logic only);
        for (int r = 0; r < 3; r++) begin
            bm = (r == EV_REG[i]) ? 8'(1 << EV_BIT[i]) : 8'h00;
            u_cefm_host_model.wr(8'(8'h12 + r), only ? bm : ~bm);
        end
    endtask : set_masks

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #300us;
        fail_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        tally_and_finish();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int a = 8'h0E; a <= 8'h15; a++) begin
            rd_check(8'(a), 8'h00);
        end
        $display("test reset_values done");
        for (int a = 0; a < 4; a++) begin
            u_cefm_host_model.wr(8'(8'h11 + a), 8'hFF);
        end
        rd_check(8'h11, 8'h00);
        rd_check(8'h12, 8'hF9);
        rd_check(8'h13, 8'h97);
        rd_check(8'h14, 8'hF9);
        $display("test access_kinds done");
        ev[12] = 1'b1;
        repeat (3) @(negedge clk);
        reg_reset_cmd = 1'b1;
        @(negedge clk);
        reg_reset_cmd = 1'b0;
        ev[12] = 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd_check(8'(8'h11 + a), 8'h00);
        end
        $display("test register_reset done");
        ev[0] = 1'b1;
        pulse(1'b0);
        rd_check(8'h0F, 8'h00);
        ev[0] = 1'b0;
        one_shot_mode = 1'b1;
        $display("test continuous_mode done");
        for (int i = 0; i < 17; i++) begin
            set_masks(i, 1'b1);
            ev[i] = 1'b1;
            pulse(1'b0);
            rd_check(8'(8'h0F + EV_REG[i]), 8'(1 << EV_BIT[i]));
            ev[i] = 1'b0;
            pulse(1'b0);
            u_cefm_host_model.rd(8'(8'h0F + EV_REG[i]), rv);
            set_masks(i, 1'b0);
            ev[i] = 1'b1;
            pulse(1'b1);
            rd_check(8'(8'h0F + EV_REG[i]), 8'(1 << EV_BIT[i]));
            rd_check(8'(8'h0F + EV_REG[i]), 8'h00);
            ev[i] = 1'b0;
            repeat (ALERT_LEN + 8) @(negedge clk);
            u_cefm_host_model.rd(8'(8'h0F + EV_REG[i]), rv);
        end
        $display("test event_sources done");
        // an event landing on the very edge that reads its register must survive the read
        fork
            u_cefm_host_model.rd(8'h11, rv);
            begin
                @(negedge clk);
                ev[11] = 1'b1;
            end
        join
        check(rv, 8'h00);
        rd_check(8'h11, 8'h80);
        ev[11] = 1'b0;
        $display("test read_collision done");
        tally_and_finish();
    end
endmodule : cefm_top_tb

bind cefm_top cefm_top_chk #(.ALERT_LEN(ALERT_LEN)) u_cefm_top_chk (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_reset_cmd(reg_reset_cmd),
    .input_overvoltage(input_overvoltage), .reg_rdata(reg_rdata), .alert_n(alert_n));

`default_nettype wire
